// ### core/udte_pkg.sv
// Shared constants and types for the USB device transaction engine
package udte_pkg;
   // Token kinds as delivered by the packet layer
   localparam logic [1:0] UDTE_TOK_OUT = 2'h0;
   localparam logic [1:0] UDTE_TOK_IN = 2'h1;
   localparam logic [1:0] UDTE_TOK_SETUP = 2'h2;
   // Handshake codes handed to the packet layer
   localparam logic [1:0] UDTE_HS_ACK = 2'h0;
   localparam logic [1:0] UDTE_HS_NAK = 2'h1;
   localparam logic [1:0] UDTE_HS_STALL = 2'h2;
   // Endpoint field codes
   localparam logic [3:0] UDTE_EP0_CODE = 4'h0;
   localparam logic [3:0] UDTE_EP1_CODE = 4'h1;
   localparam logic [3:0] UDTE_EP2_CODE = 4'h2;
   // Reset values
   localparam logic [6:0] UDTE_ADDR_RST = 7'h00;
   localparam logic [2:0] UDTE_TOG_RST = 3'h0;
   // Setup data length and buffer geometry
   localparam logic [3:0] UDTE_SETUP_LEN = 4'h8;
   localparam int UDTE_BUF_W = 11;
   // Transaction states
   typedef enum logic [1:0] {
      UDTE_IDLE = 2'b00,
      UDTE_RX = 2'b01,
      UDTE_TX = 2'b10
   } udte_state_t;
endpackage

// ### core/udte_buf2.sv
// Two-entry valid/ready buffer with registered outputs
`timescale 1ns/100ps
module udte_buf2
   import udte_pkg::*;
(
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [UDTE_BUF_W-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [UDTE_BUF_W-1:0] out_data
);
   logic [UDTE_BUF_W-1:0] skid_q;
   logic skid_v_q;
   wire push = in_valid && in_ready;
   wire pop = out_valid && out_ready;

   ////////////////////////////////////////////////////////////////////////
   // Head register drives out_data; skid holds a second word on stall
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         out_valid <= 1'b0;
         out_data <= '0;
         skid_q <= '0;
         skid_v_q <= 1'b0;
         in_ready <= 1'b1;
      end else begin
         if (!out_valid || pop) begin
            out_valid <= skid_v_q || push;
            out_data <= skid_v_q ? skid_q : in_data;
            skid_q <= in_data;
            skid_v_q <= skid_v_q && push;
            in_ready <= 1'b1;
         end else if (push) begin
            skid_q <= in_data;
            skid_v_q <= 1'b1;
            in_ready <= 1'b0; // Both entries now full
         end
      end
   end
endmodule // udte_buf2

// ### core/udte_engine.sv
// USB device transaction engine: handshakes, data toggles, control stages
`timescale 1ns/100ps
module udte_engine
   import udte_pkg::*;
(
   input wire logic clk,
   input wire logic sys_rst,
   // Token from the packet layer
   input wire logic tok_valid,
   input wire logic [1:0] tok_kind,
   input wire logic [6:0] tok_addr,
   input wire logic [3:0] tok_endp,
   // Received data packet bytes and end
   input wire logic rx_valid,
   input wire logic [7:0] rx_byte,
   output logic rx_ready,
   input wire logic rx_done,
   input wire logic rx_err,
   input wire logic rx_data1,
   // Host handshake after our data packet
   input wire logic host_ack,
   input wire logic host_timeout,
   // Transmit requests to the packet layer
   output logic tx_start,
   output logic [1:0] tx_ep,
   output logic tx_data1,
   output logic hs_send,
   output logic [1:0] hs_code,
   // Software side: endpoint readiness, stalls, address, status stage
   input wire logic ep0_rx_ok,
   input wire logic ep1_rx_ok,
   input wire logic ep0_tx_rdy,
   input wire logic ep2_tx_rdy,
   input wire logic [2:0] ep_halt,
   input wire logic status_stage,
   input wire logic addr_load,
   input wire logic [6:0] addr_new,
   // Received stream to software
   output logic sw_valid,
   input wire logic sw_ready,
   output logic [7:0] sw_byte,
   output logic sw_setup,
   output logic [1:0] sw_ep,
   // Completion pulse per acknowledged transaction, then the current device address
   output logic done,
   output logic [1:0] done_ep,
   output logic [6:0] dev_addr
);
   udte_state_t state_q, state_d;
   logic [2:0] tog_q;
   logic [1:0] ep_q;
   logic setup_q, take_q, halt_q;
   logic [UDTE_BUF_W-1:0] sw_word;

   ////////////////////////////////////////////////////////////////////////
   // Token decode: address match and endpoint legality
   wire addr_hit = (tok_addr == dev_addr);
   wire ep_legal = (tok_endp == UDTE_EP0_CODE) || (tok_endp == UDTE_EP1_CODE)
                   || (tok_endp == UDTE_EP2_CODE);
   wire [1:0] tok_ep = tok_endp[1:0];
   wire tok_hit = tok_valid && addr_hit && ep_legal && (state_q == UDTE_IDLE);
   wire is_setup = tok_kind == UDTE_TOK_SETUP;
   wire is_in = tok_kind == UDTE_TOK_IN;
   wire is_out = tok_kind == UDTE_TOK_OUT;
   // SETUP goes to endpoint 0 only
   wire setup_go = tok_hit && is_setup && (tok_ep == 2'h0);
   // Fixed directions: 0 both ways, 1 receive, 2 transmit
   wire out_dir_ok = (tok_ep != 2'h2);
   wire in_dir_ok = (tok_ep != 2'h1);
   wire out_go = tok_hit && is_out;
   wire in_go = tok_hit && is_in;
   wire in_halt = !in_dir_ok || ep_halt[tok_ep];
   wire in_rdy = (tok_ep == 2'h0) ? ep0_tx_rdy : ep2_tx_rdy;
   wire out_rdy = (tok_ep == 2'h0) ? ep0_rx_ok : ep1_rx_ok;
   wire in_send = in_go && !in_halt && in_rdy;
   // Received data end: no handshake on error
   wire rx_end = (state_q == UDTE_RX) && rx_done;
   wire rx_good = rx_end && !rx_err;
   // Toggle check on OUT data; setup always DATA0
   wire tog_match = setup_q ? !rx_data1 : (rx_data1 == tog_q[ep_q]);
   wire out_ack = rx_good && !halt_q && take_q;
   wire tx_end_ack = (state_q == UDTE_TX) && host_ack;
   wire tx_end_lost = (state_q == UDTE_TX) && host_timeout;
   // Bytes reach software only when the stage accepts them
   wire push = (state_q == UDTE_RX) && rx_valid && take_q && !halt_q;
   assign sw_word = {setup_q, ep_q, rx_byte};

   ////////////////////////////////////////////////////////////////////////
   // Transaction state sequence
   always_comb begin
      state_d = state_q;
      unique case (state_q)
         UDTE_IDLE: begin
            if (setup_go || (out_go && tok_ep != 2'h0) || (out_go && out_dir_ok)) begin
               state_d = UDTE_RX;
            end else if (in_send) begin
               state_d = UDTE_TX;
            end
         end
         UDTE_RX: begin
            if (rx_done) begin
               state_d = UDTE_IDLE;
            end
         end
         UDTE_TX: begin
            if (host_ack || host_timeout) begin
               state_d = UDTE_IDLE;
            end
         end
         default: state_d = UDTE_IDLE;
      endcase
   end

   // Stage flags captured at the token
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         state_q <= UDTE_IDLE;
         ep_q <= 2'h0;
         setup_q <= 1'b0;
         take_q <= 1'b0;
         halt_q <= 1'b0;
      end else begin
         state_q <= state_d;
         if (tok_hit) begin
            ep_q <= tok_ep;
            setup_q <= is_setup;
            take_q <= is_setup || out_rdy; // Setup is never refused
            halt_q <= !is_setup && (!out_dir_ok || ep_halt[tok_ep]);
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Per-endpoint toggles; setup forces DATA1 next, status stage DATA1
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         tog_q <= UDTE_TOG_RST;
      end else if (rx_good && setup_q) begin
         tog_q[0] <= 1'b1;
      end else if (status_stage) begin
         tog_q[0] <= 1'b1;
      end else if ((out_ack && tog_match) || tx_end_ack) begin
         tog_q[ep_q] <= ~tog_q[ep_q];
      end
   end

   // Device address, zero until software loads a new one
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         dev_addr <= UDTE_ADDR_RST;
      end else if (addr_load) begin
         dev_addr <= addr_new;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Handshake and data start pulses toward the packet layer
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         hs_send <= 1'b0;
         hs_code <= UDTE_HS_ACK;
         tx_start <= 1'b0;
         tx_ep <= 2'h0;
         tx_data1 <= 1'b0;
      end else begin
         hs_send <= (in_go && !in_send) || rx_good;
         tx_start <= in_send;
         if (in_go) begin
            tx_ep <= tok_ep;
            tx_data1 <= tog_q[tok_ep];
            hs_code <= in_halt ? UDTE_HS_STALL : UDTE_HS_NAK;
         end else if (rx_good) begin
            // Stall only after the host's data packet
            hs_code <= halt_q ? UDTE_HS_STALL :
                       (take_q ? UDTE_HS_ACK : UDTE_HS_NAK);
         end
      end
   end

   // Completion pulse: acknowledged receive or acknowledged send
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         done <= 1'b0;
         done_ep <= 2'h0;
      end else begin
         done <= out_ack || tx_end_ack;
         if (out_ack || tx_end_ack) begin
            done_ep <= ep_q;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Two-entry buffer keeps bytes when software stalls
   udte_buf2 u_buf (
      .clk(clk),
      .sys_rst(sys_rst),
      .in_valid(push),
      .in_ready(rx_ready),
      .in_data(sw_word),
      .out_valid(sw_valid),
      .out_ready(sw_ready),
      .out_data({sw_setup, sw_ep, sw_byte})
   );

   ////////////////////////////////////////////////////////////////////////
   // Checks
   sequence s_in_token;
      tok_hit && is_in;
   endsequence
   sequence s_good_rx;
      rx_good;
   endsequence

   AST_NO_TX_WITHOUT_IN: assert property (@(posedge clk) disable iff (sys_rst)
      tx_start |-> $past(in_go))
      else $error("data sent without IN token");
   AST_IN_NAK: assert property (@(posedge clk) disable iff (sys_rst)
      s_in_token ##0 (in_dir_ok && !ep_halt[tok_ep] && !in_rdy)
      |=> hs_send && hs_code == UDTE_HS_NAK && !tx_start)
      else $error("IN without data not NAKed");
   AST_IN_STALL: assert property (@(posedge clk) disable iff (sys_rst)
      s_in_token ##0 in_halt |=> hs_send && hs_code == UDTE_HS_STALL && !tx_start)
      else $error("halted IN not stalled");
   AST_IN_DATA: assert property (@(posedge clk) disable iff (sys_rst)
      s_in_token ##0 in_send |=> tx_start && !hs_send && tx_data1 == $past(tog_q[tok_ep]))
      else $error("ready IN did not start data");
   AST_RX_ERR_SILENT: assert property (@(posedge clk) disable iff (sys_rst)
      (rx_end && rx_err) |=> !hs_send)
      else $error("handshake after bad packet");
   AST_OUT_ACK: assert property (@(posedge clk) disable iff (sys_rst)
      s_good_rx ##0 (!halt_q && take_q) |=> hs_send && hs_code == UDTE_HS_ACK && done)
      else $error("accepted OUT not ACKed");
   AST_OUT_NAK: assert property (@(posedge clk) disable iff (sys_rst)
      s_good_rx ##0 (!halt_q && !take_q) |=> hs_send && hs_code == UDTE_HS_NAK)
      else $error("refused OUT not NAKed");
   AST_SETUP_ACK: assert property (@(posedge clk) disable iff (sys_rst)
      s_good_rx ##0 setup_q |=> hs_send && hs_code == UDTE_HS_ACK ##0 tog_q[0])
      else $error("setup not ACKed or toggle not DATA1");
   AST_STATUS_DATA1: assert property (@(posedge clk) disable iff (sys_rst)
      status_stage && !(rx_good && setup_q) |=> tog_q[0])
      else $error("status stage not DATA1");
   AST_BAD_EP_IGNORED: assert property (@(posedge clk) disable iff (sys_rst)
      (tok_valid && !ep_legal && state_q == UDTE_IDLE) |=> !hs_send && !tx_start)
      else $error("invalid endpoint answered");
   AST_TOG_HOLD_LOST: assert property (@(posedge clk) disable iff (sys_rst)
      tx_end_lost && !status_stage |=> $stable(tog_q))
      else $error("toggle moved without ACK");

   // Wrong-direction OUT end and acknowledged send, named for the checks below
   sequence s_out_wrong_dir;
      rx_good && !setup_q && (ep_q == 2'h2);
   endsequence
   sequence s_host_ack;
      tx_end_ack && !status_stage;
   endsequence

   AST_ADDR_MISS_IGNORED: assert property (@(posedge clk) disable iff (sys_rst)
      (tok_valid && !addr_hit && state_q == UDTE_IDLE) |=> !hs_send && !tx_start)
      else $error("token for another address answered");

   AST_SETUP_EP0_ONLY: assert property (@(posedge clk) disable iff (sys_rst)
      (tok_hit && is_setup && tok_ep != 2'h0) |=> state_q == UDTE_IDLE && !hs_send)
      else $error("setup to a data endpoint taken");

   AST_ADDR_LOAD: assert property (@(posedge clk) disable iff (sys_rst)
      addr_load |=> dev_addr == $past(addr_new))
      else $error("new address not taken");

   AST_OUT_WRONG_DIR: assert property (@(posedge clk) disable iff (sys_rst)
      s_out_wrong_dir |=> hs_send && hs_code == UDTE_HS_STALL && !done)
      else $error("OUT to transmit endpoint not stalled");

   AST_TX_TOGGLE: assert property (@(posedge clk) disable iff (sys_rst)
      s_host_ack |=> tog_q[ep_q] != $past(tog_q[ep_q]) && done)
      else $error("acknowledged send did not advance toggle");

   AST_NAK_NO_DONE: assert property (@(posedge clk) disable iff (sys_rst)
      s_good_rx ##0 (!take_q && !status_stage) |=> !done && $stable(tog_q))
      else $error("refused OUT completed or toggled");

   AST_DONE_AFTER_ACK: assert property (@(posedge clk) disable iff (sys_rst)
      done |-> $past(out_ack || tx_end_ack))
      else $error("completion without acknowledge");
endmodule // udte_engine

// ### bench/udte_host_model.sv
// Host-side model: tokens, OUT data bytes and host handshakes
`timescale 1ns/100ps
module udte_host_model
   import udte_pkg::*;
(
   input wire logic clk,
   input wire logic rx_ready,
   output logic tok_valid,
   output logic [1:0] tok_kind,
   output logic [6:0] tok_addr,
   output logic [3:0] tok_endp,
   output logic rx_valid,
   output logic [7:0] rx_byte,
   output logic rx_done,
   output logic rx_err,
   output logic rx_data1,
   output logic host_ack,
   output logic host_timeout
);
   ////////////////////////////////////////////////////////////////////////////
   // Idle lines at time zero
   initial begin
      {tok_valid, tok_kind, tok_addr, tok_endp} = '0;
      {rx_valid, rx_byte, rx_done, rx_err, rx_data1, host_ack, host_timeout} = '0;
   end
   // Every transaction opens with a token from this side
   task automatic token(input logic [1:0] k, input logic [6:0] a, input logic [3:0] e);
      @(negedge clk);
      {tok_valid, tok_kind, tok_addr, tok_endp} = {1'b1, k, a, e};
      @(negedge clk);
      tok_valid = 1'b0;
   endtask
   // Byte held until taken; inverted afterwards so stale data never looks valid
   task automatic send_byte(input logic [7:0] b);
      logic ok;
      @(negedge clk);
      {rx_valid, rx_byte} = {1'b1, b};
      ok = rx_ready;
      while (!ok) begin
         @(negedge clk);
         ok = rx_ready;
      end
      @(negedge clk);
      {rx_valid, rx_byte} = {1'b0, ~b};
   endtask
   // Packet end with error and PID flags
   task automatic finish(input logic err, input logic d1);
      @(negedge clk);
      {rx_done, rx_err, rx_data1} = {1'b1, err, d1};
      @(negedge clk);
      {rx_done, rx_err, rx_data1} = {1'b0, ~err, ~d1};
   endtask
   // Host answer to our data: ACK, or silence after a damaged packet
   task automatic reply(input logic ack);
      @(negedge clk);
      {host_ack, host_timeout} = {ack, ~ack};
      @(negedge clk);
      {host_ack, host_timeout} = 2'b00;
   endtask
endmodule // udte_host_model

// ### bench/test_udte_engine.sv
// Self-checking bench for the USB device transaction engine
`timescale 1ns/100ps
module test_udte_engine;
   import udte_pkg::*;
   logic clk = 1'b0, sys_rst = 1'b1, sw_ready = 1'b0, hold_sw = 1'b0, status_stage = 1'b0;
   logic ep0_rx_ok = 1'b1, ep1_rx_ok = 1'b1, ep0_tx_rdy = 1'b1, ep2_tx_rdy = 1'b1;
   logic [2:0] ep_halt = 3'h0;
   logic addr_load = 1'b0;
   logic [6:0] addr_new = 7'h00, cur_addr = 7'h00;
   logic [7:0] rnd = 8'h4C;
   wire logic tok_valid, rx_valid, rx_ready, rx_done, rx_err, rx_data1, host_ack, host_timeout;
   wire logic tx_start, tx_data1, hs_send, sw_valid, sw_setup, done;
   wire logic [1:0] tok_kind, tx_ep, hs_code, sw_ep, done_ep;
   wire logic [6:0] tok_addr, dev_addr;
   wire logic [3:0] tok_endp;
   wire logic [7:0] rx_byte, sw_byte;
   logic [3:0] ev_q[$];
   logic [10:0] sw_q[$];
   logic [1:0] dn_q[$];
   int n_errors = 0, checked = 0, cycles = 0;
   udte_engine udte_engine_inst(.clk(clk), .sys_rst(sys_rst), .tok_valid(tok_valid),
      .tok_kind(tok_kind), .tok_addr(tok_addr), .tok_endp(tok_endp), .rx_valid(rx_valid),
      .rx_byte(rx_byte), .rx_ready(rx_ready), .rx_done(rx_done), .rx_err(rx_err),
      .rx_data1(rx_data1), .host_ack(host_ack), .host_timeout(host_timeout),
      .tx_start(tx_start), .tx_ep(tx_ep), .tx_data1(tx_data1), .hs_send(hs_send),
      .hs_code(hs_code), .ep0_rx_ok(ep0_rx_ok), .ep1_rx_ok(ep1_rx_ok),
      .ep0_tx_rdy(ep0_tx_rdy), .ep2_tx_rdy(ep2_tx_rdy), .ep_halt(ep_halt),
      .status_stage(status_stage), .addr_load(addr_load), .addr_new(addr_new),
      .sw_valid(sw_valid), .sw_ready(sw_ready), .sw_byte(sw_byte), .sw_setup(sw_setup),
      .sw_ep(sw_ep), .done(done), .done_ep(done_ep), .dev_addr(dev_addr));
   udte_host_model udte_host_model_inst(.clk(clk), .rx_ready(rx_ready),
      .tok_valid(tok_valid), .tok_kind(tok_kind), .tok_addr(tok_addr), .tok_endp(tok_endp),
      .rx_valid(rx_valid), .rx_byte(rx_byte), .rx_done(rx_done), .rx_err(rx_err),
      .rx_data1(rx_data1), .host_ack(host_ack), .host_timeout(host_timeout));
   ////////////////////////////////////////////////////////////////////////////
   // Reporting and comparison
   task automatic final_report;
      if (n_errors == 0 && checked > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic tally(input logic ok, input logic [10:0] g, input logic [10:0] e);
      checked++;
      if (!ok) begin
         n_errors++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   task automatic compare_ev(input logic [3:0] g, input logic [3:0] e);
      tally(g === e, 11'(g), 11'(e));
   endtask
   task automatic compare_sw(input logic [10:0] g, input logic [10:0] e);
      tally(g === e, g, e);
   endtask
   task automatic compare_addr(input logic [6:0] g, input logic [6:0] e);
      tally(g === e, 11'(g), 11'(e));
   endtask
   task automatic compare_done(input logic [1:0] g, input logic [1:0] e);
      tally(g === e, 11'(g), 11'(e));
   endtask
   function automatic logic [7:0] lfsr(input logic [7:0] s);
      return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
   endfunction
   ////////////////////////////////////////////////////////////////////////////
   // Clock, random receiver stalls, hang guard
   always #20 clk = ~clk;
   always @(negedge clk) begin
      rnd <= lfsr(rnd);
      sw_ready <= !hold_sw && rnd[0];
   end
   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         n_errors++;
         final_report();
      end
   end
   // Pulses read mid-cycle; an event with no note is matched against an impossible code
   always @(negedge clk) begin
      if (!sys_rst && (hs_send === 1'b1 || tx_start === 1'b1))
         compare_ev(tx_start ? {1'b1, tx_ep, tx_data1} : {2'b00, hs_code},
            ev_q.size() ? ev_q.pop_front() : 4'h7);
   end
   // Completion pulse names the endpoint whose transaction was acknowledged
   always @(negedge clk) begin
      if (!sys_rst && done === 1'b1)
         compare_done(done_ep, dn_q.size() ? dn_q.pop_front() : 2'h3);
   end
   // Stream words taken on the handshake edge, in order
   always @(posedge clk) begin
      if (!sys_rst && sw_valid === 1'b1 && sw_ready === 1'b1)
         compare_sw({sw_setup, sw_ep, sw_byte}, sw_q.size() ? sw_q.pop_front() : 11'h7FF);
   end
   ////////////////////////////////////////////////////////////////////////////
   // Transaction helpers
   task automatic ev(input logic [3:0] c);
      ev_q.push_back(c);
   endtask
   task automatic out_pkt(input logic [1:0] k, input logic [3:0] e, input int n,
         input logic err, input logic d1, input logic keep);
      logic [7:0] b;
      // A good packet answered with ACK completes on the addressed endpoint
      if (!err && ev_q.size() && ev_q[$] == {2'b00, UDTE_HS_ACK}) dn_q.push_back(e[1:0]);
      udte_host_model_inst.token(k, cur_addr, e);
      for (int i = 0; i < n; i++) begin
         b = rnd ^ 8'(i);
         if (keep) sw_q.push_back({k == UDTE_TOK_SETUP, e[1:0], b});
         udte_host_model_inst.send_byte(b);
      end
      udte_host_model_inst.finish(err, d1);
      repeat (3) @(negedge clk);
   endtask
   task automatic in_pkt(input logic [3:0] e, input logic [1:0] r);
      if (r == 2'd1) dn_q.push_back(e[1:0]);
      udte_host_model_inst.token(UDTE_TOK_IN, cur_addr, e);
      if (r != 2'd0) udte_host_model_inst.reply(r == 2'd1);
      repeat (3) @(negedge clk);
   endtask
   ////////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      repeat (12) @(negedge clk);
      sys_rst = 1'b0;
      compare_addr(dev_addr, UDTE_ADDR_RST);
      ev(4'hC); in_pkt(4'h2, 2'd1);
      ev(4'hD); in_pkt(4'h2, 2'd2);
      ev(4'hD); in_pkt(4'h2, 2'd1);
      ev(4'hC); in_pkt(4'h2, 2'd1);
      ep2_tx_rdy = 1'b0;
      ev({2'b00, UDTE_HS_NAK}); in_pkt(4'h2, 2'd0);
      {ep2_tx_rdy, ep_halt} = {1'b1, 3'h4};
      ev({2'b00, UDTE_HS_STALL}); in_pkt(4'h2, 2'd0);
      ep_halt = 3'h0;
      ev({2'b00, UDTE_HS_STALL}); out_pkt(UDTE_TOK_OUT, 4'h2, 3, 0, 0, 0);
      ev({2'b00, UDTE_HS_STALL}); in_pkt(4'h1, 2'd0);
      ev({2'b00, UDTE_HS_ACK}); out_pkt(UDTE_TOK_OUT, 4'h1, 5, 0, 0, 1);
      ep1_rx_ok = 1'b0;
      ev({2'b00, UDTE_HS_NAK}); out_pkt(UDTE_TOK_OUT, 4'h1, 3, 0, 1, 0);
      {ep1_rx_ok, ep_halt} = {1'b1, 3'h2};
      ev({2'b00, UDTE_HS_STALL}); out_pkt(UDTE_TOK_OUT, 4'h1, 2, 0, 1, 0);
      ep_halt = 3'h0;
      out_pkt(UDTE_TOK_OUT, 4'h1, 0, 1, 1, 0);
      ev({2'b00, UDTE_HS_ACK}); out_pkt(UDTE_TOK_OUT, 4'h1, 0, 0, 1, 0);
      // Receiver stalled: buffer must refuse, then drain with nothing lost
      hold_sw = 1'b1;
      ev({2'b00, UDTE_HS_ACK});
      fork
         out_pkt(UDTE_TOK_OUT, 4'h1, 8, 0, 0, 1);
         begin
            repeat (40) @(negedge clk);
            tally(rx_ready === 1'b0, 11'(rx_ready), 11'h0);
            hold_sw = 1'b0; // Software empties the stream
         end
      join
      // Control read: setup, three data stages, forced status toggle
      ev({2'b00, UDTE_HS_ACK}); out_pkt(UDTE_TOK_SETUP, 4'h0, 8, 0, 0, 1);
      ev(4'h9); in_pkt(4'h0, 2'd1);
      ev(4'h8); in_pkt(4'h0, 2'd1);
      // Third stage leaves DATA0 next, so only the forced status toggle gives DATA1
      ev(4'h9); in_pkt(4'h0, 2'd1);
      @(negedge clk) status_stage = 1'b1;
      @(negedge clk) status_stage = 1'b0;
      ev(4'h9); in_pkt(4'h0, 2'd1);
      ev({2'b00, UDTE_HS_ACK}); out_pkt(UDTE_TOK_OUT, 4'h0, 0, 0, 1, 0);
      out_pkt(UDTE_TOK_SETUP, 4'h0, 0, 1, 0, 0);
      udte_host_model_inst.token(UDTE_TOK_SETUP, cur_addr, 4'h1);
      for (int e = 3; e < 16; e++) udte_host_model_inst.token(UDTE_TOK_IN, cur_addr, 4'(e));
      // New address: old one ignored, new one answered
      @(negedge clk) {addr_load, addr_new} = {1'b1, 7'h2A};
      @(negedge clk) addr_load = 1'b0;
      compare_addr(dev_addr, 7'h2A);
      in_pkt(4'h2, 2'd0);
      cur_addr = 7'h2A;
      ev(4'hD); in_pkt(4'h2, 2'd1);
      // Reset in mid-run: address and toggles return to their reset values
      sys_rst = 1'b1;
      repeat (2) @(negedge clk);
      sys_rst = 1'b0;
      compare_addr(dev_addr, UDTE_ADDR_RST);
      cur_addr = UDTE_ADDR_RST;
      ev(4'hC); in_pkt(4'h2, 2'd1);
      repeat (10) @(negedge clk);
      tally(ev_q.size() == 0 && sw_q.size() == 0 && dn_q.size() == 0,
         11'(ev_q.size() + sw_q.size()), 11'(dn_q.size()));
      final_report();
   end
endmodule // test_udte_engine
